// >>> hdl/pdsc_pkg.sv
package pdsc_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SETTLE_NS = 150;
  localparam int unsigned SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETTLE_CYC = SETTLE_CYC_INT[3:0];
  localparam logic [1:0] RISE_EDGES_TO_LATCH = 2'h2;

  // ************************************************************
  // Counters and phase taps
  // ************************************************************
  localparam int unsigned NUM_POST = 10;
  localparam int unsigned NUM_CNT = NUM_POST + 1;
  localparam int unsigned TAP_W = 3;
  localparam int unsigned TAPS_PER_VCO = 8;
  localparam logic [2:0] TAP_RESET = 3'h0;
  localparam int unsigned CNT_IDX_M = 0;
  localparam logic [3:0] SEL_ALL_POST = 4'h0;
  localparam logic [3:0] SEL_M = 4'h1;
  localparam logic [3:0] SEL_POST_FIRST = 4'h2;
  localparam logic [3:0] SEL_POST_LAST = 4'hb;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADR_TAP_POST = 8'h10;
  localparam logic [7:0] ADR_TAP_M = 8'h14;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_BADSEL_BIT = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_DIR_BIT = 2;
  localparam int unsigned STAT_SEL_LSB = 4;
  localparam int unsigned STAT_COUNT_LSB = 16;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    PDSC_IDLE,
    PDSC_ARMED,
    PDSC_SHIFT
  } pdsc_state_t;

  typedef struct packed {
    logic scanclk;
    logic step;
    logic up;
    logic [3:0] sel;
  } pdsc_link_t;

  typedef struct packed {
    pdsc_state_t st;
    pdsc_link_t sync1;
    pdsc_link_t sync2;
    logic clk_d;
    logic step_prev;
    logic [1:0] rise_cnt;
    logic [3:0] settle_cnt;
    logic done;
    logic dir_l;
    logic [3:0] sel_l;
    logic [NUM_CNT-1:0][TAP_W-1:0] taps;
    logic enable;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] step_count;
    logic ack;
    logic [31:0] rdata;
  } pdsc_regs_t;

endpackage

// >>> hdl/pdsc_phase_step.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Each finished step moves the chosen tap one eighth VCO period, up or down.
// - A step changes the taps feeding one post-scale counter, all post-scale counters, or the feedback counter.
// - Output clocks keep running; only tap selections change during a step.
// - Steps come only from the parallel step pins, never from a scan chain.
// - Four-bit select on rising edge; zero means all post counters, one means feedback.
// - Select codes two to eleven pick post counters zero to nine in order.
// - Direction sampled on rising edge; one advances, zero retards the phase.
// - One step per request assertion; a new step needs request low then high.
// - Step request is sampled on the falling link clock edge.
// - Second rising edge after capture latches direction and select and starts shifting.
// - Done flag falls on that edge and stays low until the shift ends.
// - Done rises from internal timing, not a link clock edge; low time is a fixed three system clocks.
// - All step controls are captured on link clock edges only.
module pdsc_phase_step
  import pdsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic scanclk_i,
  input wire logic phase_step_i,
  input wire logic phase_up_i,
  input wire logic [3:0] counter_sel_i,
  output logic phase_done_o,
  output logic [NUM_CNT-1:0][TAP_W-1:0] tap_sel_o
);

  // ************************************************************
  // Select decode
  // ************************************************************
  // Bit 0 is the feedback counter, bits 1..10 the post counters
  function automatic logic [NUM_CNT-1:0] decode_sel(input logic [3:0] sel);
    logic [NUM_CNT-1:0] mask;
    mask = '0;
    if (sel == SEL_ALL_POST)
    begin
      mask = {{NUM_POST{1'b1}}, 1'b0};
    end
    else if (sel == SEL_M)
    begin
      mask[CNT_IDX_M] = 1'b1;
    end
    else if (sel >= SEL_POST_FIRST && sel <= SEL_POST_LAST)
    begin
      mask[sel - SEL_POST_FIRST + 4'h1] = 1'b1;
    end
    // Codes above the last post counter leave the mask empty
    return mask;
  endfunction

  function automatic logic [TAP_W-1:0] step_tap(input logic [TAP_W-1:0] tap, input logic up);
    // Eight taps per VCO period, wrapping modulo the tap count
    logic [TAP_W-1:0] one;
    one = TAP_W'(1);
    if (up)
    begin
      return tap + one;
    end
    return tap - one;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  pdsc_regs_t r;
  pdsc_regs_t next_r;

  logic rise;
  logic fall;
  logic step_seen;
  logic latch_edge;
  logic busy;
  logic [NUM_CNT-1:0][TAP_W-1:0] tap_stepped;
  logic bus_req;
  logic bus_wr;
  logic [NUM_CNT-1:0] mask;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irq_clr;

  // ************************************************************
  // Link clock edge detection
  // ************************************************************
  // Link clock is just another asynchronous input; edges come from the
  // synchronised copy so data and clock share the same pipeline delay
  assign rise = r.sync2.scanclk & ~r.clk_d;
  assign fall = ~r.sync2.scanclk & r.clk_d;

  // Fresh request: high now, low at the previous falling edge
  assign step_seen = fall & r.sync2.step & ~r.step_prev;

  // Second rising edge since capture; two bits are enough for the count
  assign latch_edge = rise & ((r.rise_cnt + 2'h1) == RISE_EDGES_TO_LATCH);

  // Busy from capture until done rises again
  assign busy = (r.st != PDSC_IDLE);

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Only byte lane 0 carries writable bits, so other lanes are ignored
  assign bus_req = wb_cyc_i & wb_stb_i & ~r.ack;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];

  // ************************************************************
  // Counter select and tap arithmetic
  // ************************************************************
  assign mask = decode_sel(r.sync2.sel);

  // One stepper per counter; the sequencer decides which results land.
  // Costs eleven small adders but keeps the latch edge a single mux level.
  generate
    for (genvar g = 0; g < NUM_CNT; g++)
    begin : g_tap
      assign tap_stepped[g] = step_tap(r.taps[g], r.sync2.up);
    end
  endgenerate

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    next_r = r;
    events = '0;
    irq_clr = '0;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    next_r.sync1.scanclk = scanclk_i;
    next_r.sync1.step = phase_step_i;
    next_r.sync1.up = phase_up_i;
    next_r.sync1.sel = counter_sel_i;
    next_r.sync2 = r.sync1;
    next_r.clk_d = r.sync2.scanclk;

    // ************************************************************
    // Step sequencer
    // ************************************************************
    if (fall)
    begin
      next_r.step_prev = r.sync2.step;
    end

    case (r.st)
      PDSC_IDLE:
      begin
        // Only a low-to-high seen across falling edges starts a step,
        // so a request held high cannot fire twice
        if (step_seen && r.enable)
        begin
          next_r.st = PDSC_ARMED;
          next_r.rise_cnt = '0;
        end
      end
      PDSC_ARMED:
      begin
        if (rise)
        begin
          next_r.rise_cnt = r.rise_cnt + 2'h1;
          if (latch_edge)
          begin
            // Controls are assumed settled well before this edge
            next_r.dir_l = r.sync2.up;
            next_r.sel_l = r.sync2.sel;
            next_r.done = 1'b0;
            next_r.settle_cnt = SETTLE_CYC;
            next_r.st = PDSC_SHIFT;
            // Taps move in place; counters never stop
            for (int i = 0; i < NUM_CNT; i++)
            begin
              if (mask[i])
              begin
                next_r.taps[i] = tap_stepped[i];
              end
            end
            if (mask == '0)
            begin
              events[IRQ_BADSEL_BIT] = 1'b1;
            end
          end
        end
      end
      PDSC_SHIFT:
      begin
        // Internal settle time on the system clock, unrelated to link edges.
        // Fixed length keeps done low time independent of the link rate;
        // a slow link therefore sees done low for well under one period.
        if (r.settle_cnt <= 4'h1)
        begin
          next_r.done = 1'b1;
          next_r.st = PDSC_IDLE;
          next_r.step_count = r.step_count + 16'h0001;
          events[IRQ_DONE_BIT] = 1'b1;
        end
        else
        begin
          next_r.settle_cnt = r.settle_cnt - 4'h1;
        end
      end
      default:
      begin
        next_r.st = PDSC_IDLE;
      end
    endcase

    // ************************************************************
    // Register bus
    // ************************************************************
    next_r.ack = bus_req;
    if (bus_req)
    begin
      case (wb_adr_i)
        ADR_CTRL:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[CTRL_EN_BIT] = r.enable;
        end
        ADR_STATUS:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[STAT_BUSY_BIT] = busy;
          next_r.rdata[STAT_DONE_BIT] = r.done;
          next_r.rdata[STAT_DIR_BIT] = r.dir_l;
          next_r.rdata[STAT_SEL_LSB +: 4] = r.sel_l;
          next_r.rdata[STAT_COUNT_LSB +: 16] = r.step_count;
        end
        ADR_IRQ_STAT:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[IRQ_W-1:0] = r.irq_stat;
        end
        ADR_IRQ_MASK:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[IRQ_W-1:0] = r.irq_mask;
        end
        ADR_TAP_POST:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[NUM_POST*TAP_W-1:0] = r.taps[NUM_CNT-1:1];
        end
        ADR_TAP_M:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rdata[TAP_W-1:0] = r.taps[CNT_IDX_M];
        end
        default:
        begin
          // Unmapped addresses answer with zero rather than stalling the bus
          next_r.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (bus_wr)
    begin
      case (wb_adr_i)
        ADR_CTRL:
        begin
          next_r.enable = wb_dat_i[CTRL_EN_BIT];
        end
        ADR_IRQ_STAT:
        begin
          irq_clr = wb_dat_i[IRQ_W-1:0];
        end
        ADR_IRQ_MASK:
        begin
          next_r.irq_mask = wb_dat_i[IRQ_W-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    // A new event in the clearing cycle survives the clear
    next_r.irq_stat = (r.irq_stat & ~irq_clr) | events;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Done resets high so the controller may start at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= PDSC_IDLE;
      r.done <= 1'b1;
      r.enable <= CTRL_EN_RESET;
      r.irq_mask <= IRQ_MASK_RESET;
      r.taps <= {NUM_CNT{TAP_RESET}};
      r.rdata <= 32'h0000_0000;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_dat_o = r.rdata;
  // Ack lasts one cycle; a held strobe is not answered in two cycles running
  assign wb_ack_o = r.ack;
  assign irq_o = |(r.irq_stat & r.irq_mask);
  assign phase_done_o = r.done;
  // No scan chain port exists; taps change only through the step pins
  assign tap_sel_o = r.taps;

endmodule // pdsc_phase_step

`default_nettype wire

// >>> verification/pdsc_phase_step_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pdsc_phase_step_monitor
  import pdsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic phase_step_i,
  input wire logic phase_done_o,
  input wire logic [NUM_CNT-1:0][TAP_W-1:0] tap_sel_o
);
  logic [NUM_CNT-1:0][TAP_W-1:0] taps_q;
  logic rearm;
  logic [5:0] since_step;
  logic unit_ok;
  logic [2:0] d;
  always_ff @(posedge clk_i)
  begin
    taps_q <= tap_sel_o;
    rearm <= rst_i || !phase_step_i || (rearm && !$fell(phase_done_o));
    since_step <= phase_step_i ? 6'h00 : since_step + {5'h00, since_step != 6'h3f};
  end
  always_comb
  begin
    unit_ok = 1'b1;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      d = tap_sel_o[i] - taps_q[i];
      unit_ok = unit_ok && (d inside {3'h0, 3'h1, 3'h7});
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence done_fall;
    $fell(phase_done_o);
  endsequence
  sequence done_low_run;
    !phase_done_o [*3] ##1 phase_done_o;
  endsequence
  AST_ACK_ONE_CYCLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_ACK_TIMING: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DONE_LOW: assert property (done_fall |-> done_low_run)
    else $error("done low time wrong");
  AST_TAPS_ON_FALL: assert property (!$stable(tap_sel_o) |-> $fell(phase_done_o))
    else $error("taps moved outside a step");
  AST_TAP_UNIT: assert property (unit_ok)
    else $error("tap moved more than one position");
  AST_DONE_CAUSE: assert property (done_fall |-> since_step < 6'h18)
    else $error("step without request");
  AST_ONE_PER_REQ: assert property (done_fall |-> rearm)
    else $error("second step from one request");
endmodule // pdsc_phase_step_monitor
bind pdsc_phase_step pdsc_phase_step_monitor i_pdsc_phase_step_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .phase_step_i(phase_step_i),
  .phase_done_o(phase_done_o), .tap_sel_o(tap_sel_o));
`default_nettype wire

// >>> verification/pdsc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdsc_core_model
(
  input wire logic clk_i,
  input wire logic phase_done_i,
  output logic scanclk_o,
  output logic step_o,
  output logic up_o,
  output logic [3:0] sel_o
);
  initial
  begin
    scanclk_o = 1'b0;
    step_o = 1'b0;
    up_o = 1'b0;
    sel_o = 4'h0;
  end
  always #200 scanclk_o = ~scanclk_o;
  task automatic request(input logic up, input logic [3:0] sel, input int hold, input logic wait_done);
    @(posedge scanclk_o);
    @(posedge clk_i);
    up_o <= up;
    sel_o <= sel;
    @(posedge scanclk_o);
    @(posedge clk_i);
    step_o <= 1'b1;
    fork
      begin
        repeat (hold) @(posedge scanclk_o);
        @(posedge clk_i);
        step_o <= 1'b0;
      end
      if (wait_done)
      begin
        @(negedge phase_done_i);
        @(posedge phase_done_i);
      end
    join
  endtask
endmodule // pdsc_core_model
`default_nettype wire

// >>> verification/pdsc_phase_step_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pdsc_phase_step_tb_top;
  import pdsc_pkg::*;
  localparam logic [32:0] ZERO = 33'h0_0000_0000;
  localparam logic [32:0] ONE = 33'h0_0000_0001;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic scanclk;
  logic step;
  logic up;
  logic [3:0] sel;
  logic phase_done_o;
  logic [NUM_CNT-1:0][TAP_W-1:0] tap_sel_o;
  logic [NUM_CNT-1:0][TAP_W-1:0] exp_taps = '0;
  int failures = 0;
  int cmp_count = 0;
  always #25 clk_i = ~clk_i;
  pdsc_phase_step i_pdsc_phase_step (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scanclk_i(scanclk), .phase_step_i(step), .phase_up_i(up),
    .counter_sel_i(sel), .phase_done_o(phase_done_o), .tap_sel_o(tap_sel_o));
  pdsc_core_model i_pdsc_core_model (.clk_i(clk_i), .phase_done_i(phase_done_o), .scanclk_o(scanclk),
    .step_o(step), .up_o(up), .sel_o(sel));
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n >= 20) failures++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic t_reset();
    logic [31:0] q;
    logic [7:0] adrs [4] = '{ADR_CTRL, ADR_IRQ_MASK, ADR_TAP_POST, 8'h20};
    check("done", ONE, {32'h0000_0000, phase_done_o});
    for (int k = 0; k < 4; k++)
    begin
      wb_xfer(1'b0, adrs[k], 32'h0000_0000, q);
      check("reset read", k == 0 ? ONE : ZERO, {1'b0, q});
    end
  endtask
  task automatic t_codes();
    logic [31:0] q;
    for (int c = 0; c < 16; c++)
    begin
      for (int i = 0; i < NUM_CNT; i++)
        if ((c == 0 && i > 0) || (c == 1 && i == 0) || (c > 1 && c < 12 && i == c - 1))
          exp_taps[i] = c[0] ? exp_taps[i] - 3'h1 : exp_taps[i] + 3'h1;
      i_pdsc_core_model.request(~c[0], c[3:0], 2, 1'b1);
      check("taps", exp_taps, tap_sel_o);
    end
    wb_xfer(1'b0, ADR_STATUS, 32'h0000_0000, q);
    check("count", 33'h0_0000_0010, {17'h0_0000, q[31:16]});
  endtask
  task automatic t_irq();
    logic [31:0] q;
    check("irq masked", ZERO, {32'h0000_0000, irq_o});
    for (int b = 0; b < 2; b++)
    begin
      wb_xfer(1'b1, ADR_IRQ_MASK, 32'h0000_0001 << b, q);
      @(negedge clk_i);
      check("irq set", ONE, {32'h0000_0000, irq_o});
      wb_xfer(1'b1, ADR_IRQ_STAT, 32'h0000_0001 << b, q);
      @(negedge clk_i);
      check("irq clear", ZERO, {32'h0000_0000, irq_o});
    end
  endtask
  task automatic t_disable_and_hold();
    logic [31:0] q;
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0000, q);
    i_pdsc_core_model.request(1'b1, 4'h2, 2, 1'b0);
    repeat (40) @(posedge clk_i);
    check("taps off", exp_taps, tap_sel_o);
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0001, q);
    exp_taps[2] = exp_taps[2] + 3'h1;
    i_pdsc_core_model.request(1'b1, 4'h3, 6, 1'b1);
    repeat (40) @(posedge clk_i);
    check("taps held", exp_taps, tap_sel_o);
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    failures++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_codes();
    t_irq();
    t_disable_and_hold();
    conclude();
  end
endmodule // pdsc_phase_step_tb_top
`default_nettype wire
